// ### inc/pbsa_pkg.sv
package pbsa_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int WORD_W = 36;
	localparam int BURST_W = 2;
	localparam int BURST_LEN = 4;
	localparam int PIPE_LAT = 2;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0;
	localparam logic [LANES-1:0] BW_NONE = 4'hF;
	localparam logic [BURST_W-1:0] BCNT_RST = 2'h0;
	localparam logic ORDER_INTERLEAVED = 1'b1;

	typedef enum logic [1:0]
	{
		OP_NONE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} pbsa_op_t;

	typedef struct packed
	{
		pbsa_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] bw_n;
	} pbsa_stage_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// lane i = {parity[i], data[8i+7:8i]}
	function automatic logic [WORD_W-1:0] pack_word(
		input logic [DATA_W-1:0] d, input logic [LANES-1:0] p);
		logic [WORD_W-1:0] w;
		w = WORD_RST;
		for (int i = 0; i < LANES; i++)
			w[i*LANE_W +: LANE_W] = {p[i], d[i*8 +: 8]};
		return w;
	endfunction

	function automatic logic [DATA_W-1:0] word_data(
		input logic [WORD_W-1:0] w);
		logic [DATA_W-1:0] d;
		d = '0;
		for (int i = 0; i < LANES; i++)
			d[i*8 +: 8] = w[i*LANE_W +: 8];
		return d;
	endfunction

	function automatic logic [LANES-1:0] word_par(
		input logic [WORD_W-1:0] w);
		logic [LANES-1:0] p;
		p = '0;
		for (int i = 0; i < LANES; i++)
			p[i] = w[i*LANE_W + 8];
		return p;
	endfunction

	function automatic logic [WORD_W-1:0] lane_mask(
		input logic [LANES-1:0] bw_n);
		logic [WORD_W-1:0] m;
		m = WORD_RST;
		for (int i = 0; i < LANES; i++)
			m[i*LANE_W +: LANE_W] = {LANE_W{~bw_n[i]}};
		return m;
	endfunction

	function automatic logic [BURST_W-1:0] burst_offset(
		input logic [BURST_W-1:0] start, input logic [BURST_W-1:0] cnt,
		input logic interleave);
		return (interleave == ORDER_INTERLEAVED) ? (start ^ cnt) :
			BURST_W'(start + cnt);
	endfunction

endpackage

// ### verilog/pbsa_burst_ctr.sv
`timescale 1ns/1ps
`default_nettype none
module pbsa_burst_ctr
	import pbsa_pkg::*;
#(
	parameter int W = BURST_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hold,
	input wire logic load,
	input wire logic advance,
	input wire logic [W-1:0] start,
	input wire logic interleave,
	output logic [W-1:0] next_low
);
	typedef struct packed
	{
		logic [W-1:0] start;
		logic [W-1:0] cnt;
	} pbsa_bc_t;

	pbsa_bc_t st_q;
	pbsa_bc_t st_d;
	logic [W-1:0] cnt_nx;

	if (W != BURST_W)
		$error("burst counter width must match the four-word burst");

	assign cnt_nx = W'(st_q.cnt + 1'b1);
	// only the low bits move; wrap modulo four
	assign next_low = burst_offset(st_q.start, cnt_nx, interleave);

	always_comb
	begin
		st_d = st_q;
		if (!hold)
		begin
			if (load)
			begin
				st_d.start = start;
				st_d.cnt = '0;
			end
			else if (advance)
				st_d.cnt = cnt_nx;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule // pbsa_burst_ctr
`default_nettype wire

// ### verilog/pbsa_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module pbsa_skid_buf
#(
	parameter int W = 36,
	parameter int DEPTH = 2
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed
	{
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} pbsa_buf_t;

	pbsa_buf_t st_q;
	pbsa_buf_t st_d;
	logic push;
	logic pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("buffer depth must be a power of two, at least two");

	assign in_ready = (st_q.cnt != (PW+1)'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign out_data = st_q.mem[st_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wp] = in_data;
			st_d.wp = PW'(st_q.wp + 1'b1);
		end
		if (pop)
			st_d.rp = PW'(st_q.rp + 1'b1);
		if (push && !pop)
			st_d.cnt = (PW+1)'(st_q.cnt + 1'b1);
		else if (pop && !push)
			st_d.cnt = (PW+1)'(st_q.cnt - 1'b1);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule // pbsa_skid_buf
`default_nettype wire

// ### verilog/pbsa_core.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - data for a captured command moves on the bus two edges later
// - clock enable high freezes every register and output for that edge
// - load with any chip select inactive starts nothing and stops bursts
// - a deselect still finishes reads and writes already in the pipe
// - bus floats two cycles after a deselect or a write
// - the burst counter gives four words from one address
// - a static select picks linear or interleaved burst order
// - select high means interleaved, low means linear; held constant
// - advance-or-load low loads address and control, high advances
// - on advance the address pins are ignored; only live bursts move
// - address captured only on load, clock enable low, all selects true
// - read-or-write sampled at load decides read versus write
// - each 9-bit lane has its own active-low write enable
// - byte enables are ignored on reads; write-burst advances use them whatever read-or-write is
// - output enable is asynchronous and floats the bus at any time
// - reads and writes may alternate on back to back cycles
// - address, write data and control are all registered on the edge
module pbsa_core
	import pbsa_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_gate_n,
	input wire logic chip_sel_a_n,
	input wire logic chip_sel_b,
	input wire logic chip_sel_c_n,
	input wire logic advance_or_load,
	input wire logic read_write,
	input wire logic [pbsa_pkg::LANES-1:0] byte_write_n,
	input wire logic burst_order_sel,
	input wire logic out_en_n,
	input wire logic [AW-1:0] addr_in,
	input wire logic [pbsa_pkg::DATA_W-1:0] dq_data_in,
	output logic [pbsa_pkg::DATA_W-1:0] dq_data_out,
	output logic dq_data_oe_n,
	input wire logic [pbsa_pkg::LANES-1:0] dq_parity_in,
	output logic [pbsa_pkg::LANES-1:0] dq_parity_out,
	output logic dq_parity_oe_n,
	output logic burst_active
);
	import pbsa_pkg::*;

	localparam int DEPTH = 1 << AW;

	if (AW != ADDR_W || WORD_W != LANES * LANE_W)
		$error("array must stay 128K words of four 9-bit lanes");

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic act;
		logic wr;
		logic [AW-1:0] base;
		pbsa_stage_t s1;
		pbsa_stage_t s2;
		logic drive;
		logic [WORD_W-1:0] out;
	} pbsa_core_t;

	pbsa_core_t st_q;
	pbsa_core_t st_d;

	logic [WORD_W-1:0] mem [DEPTH];
	logic [WORD_W-1:0] wr_word;
	logic [WORD_W-1:0] rd_word;
	logic [WORD_W-1:0] buf_out;
	logic [BURST_W-1:0] next_low;
	logic selected;
	logic load;
	logic gate;
	logic hold;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_push;
	logic buf_pop;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign gate = clk_gate_n;
	assign selected = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
	assign load = !advance_or_load;
	assign wr_word = pack_word(dq_data_in, dq_parity_in);

	// read the array one edge early into the buffer; a write to the
	// same word landing on this edge is merged so no stale data escapes
	always_comb
	begin
		rd_word = mem[st_q.s1.addr];
		if (st_q.s2.op == OP_WRITE && st_q.s2.addr == st_q.s1.addr)
			rd_word = (rd_word & ~lane_mask(st_q.s2.bw_n)) |
				(wr_word & lane_mask(st_q.s2.bw_n));
	end

	assign buf_push = (st_q.s1.op == OP_READ) && !gate;
	assign buf_pop = (st_q.s2.op == OP_READ) && !gate;
	// a full buffer stalls the pipe like a suspended edge
	assign hold = gate || (buf_push && !buf_in_ready);

	pbsa_burst_ctr #(
		.W(BURST_W)
	) u_burst (
		.clk(clk),
		.resetn(resetn),
		.hold(hold),
		.load(load && selected),
		.advance(!load && st_q.act),
		.start(addr_in[BURST_W-1:0]),
		.interleave(burst_order_sel),
		.next_low(next_low)
	);

	pbsa_skid_buf #(
		.W(WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_rdbuf (
		.clk(clk),
		.resetn(resetn),
		.in_valid(buf_push),
		.in_ready(buf_in_ready),
		.in_data(rd_word),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out)
	);

	// ----------------------------------------------------------------
	// pipeline
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (!hold)
		begin
			// stage one: new command, burst step or nothing
			st_d.s1.op = OP_NONE;
			st_d.s1.addr = st_q.s1.addr;
			st_d.s1.bw_n = BW_NONE;
			if (load)
			begin
				if (selected)
				begin
					st_d.act = 1'b1;
					st_d.wr = !read_write;
					st_d.base = addr_in;
					st_d.s1.addr = addr_in;
					st_d.s1.op = read_write ? OP_READ : OP_WRITE;
				end
				else
					st_d.act = 1'b0;
			end
			else if (st_q.act)
			begin
				// address pins unused while advancing
				st_d.s1.addr = {st_q.base[AW-1:BURST_W], next_low};
				st_d.s1.op = st_q.wr ? OP_WRITE : OP_READ;
			end
			// enables sampled each write cycle, dropped on reads
			if (st_d.s1.op == OP_WRITE)
				st_d.s1.bw_n = byte_write_n;
			else
				st_d.s1.bw_n = BW_NONE;

			// stage two: in-flight work finishes regardless of selects
			st_d.s2 = st_q.s1;

			// data edge, two after the command
			st_d.drive = (st_q.s2.op == OP_READ);
			if (st_q.s2.op == OP_READ && buf_out_valid)
				st_d.out = buf_out;
		end
	end

	// the array is a plain store, kept out of the reset net
	always_ff @(posedge clk)
	begin
		if (!hold && st_q.s2.op == OP_WRITE)
		begin
			for (int i = 0; i < LANES; i++)
				if (!st_q.s2.bw_n[i])
					mem[st_q.s2.addr][i*LANE_W +: LANE_W] <=
						wr_word[i*LANE_W +: LANE_W];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q.act <= 1'b0;
			st_q.wr <= 1'b0;
			st_q.base <= ADDR_RST;
			st_q.s1 <= '{op: OP_NONE, addr: ADDR_RST, bw_n: BW_NONE};
			st_q.s2 <= '{op: OP_NONE, addr: ADDR_RST, bw_n: BW_NONE};
			st_q.drive <= 1'b0;
			st_q.out <= WORD_RST;
		end
		else
			st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dq_data_out = word_data(st_q.out);
	assign dq_parity_out = word_par(st_q.out);
	// output enable bypasses the clock so it can float the bus at once
	assign dq_data_oe_n = !st_q.drive || out_en_n;
	assign dq_parity_oe_n = !st_q.drive || out_en_n;
	assign burst_active = st_q.act;
endmodule // pbsa_core
`default_nettype wire

// ### sim/pbsa_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbsa_checker
	import pbsa_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_gate_n,
	input wire logic chip_sel_a_n,
	input wire logic chip_sel_b,
	input wire logic chip_sel_c_n,
	input wire logic advance_or_load,
	input wire logic read_write,
	input wire logic out_en_n,
	input wire logic [pbsa_pkg::DATA_W-1:0] dq_data_out,
	input wire logic dq_data_oe_n,
	input wire logic burst_active
);
	wire logic sel;
	assign sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence load_s;
		!clk_gate_n && !advance_or_load;
	endsequence
	// only enabled edges move the pipe
	sequence run2_s;
		!clk_gate_n [*2];
	endsequence
	a_oe_async: assert property (out_en_n |-> dq_data_oe_n)
		else $error("bus driven with output enable off");
	a_read_late: assert property (load_s ##0 (sel && read_write) ##1 run2_s
		|=> dq_data_oe_n == out_en_n) else $error("read data late");
	a_write_float: assert property (load_s ##0 (sel && !read_write)
		##1 run2_s |=> dq_data_oe_n) else $error("bus driven on write");
	a_desel_float: assert property (load_s ##0 !sel ##1 run2_s
		|=> dq_data_oe_n) else $error("bus driven after deselect");
	a_gate_hold: assert property (clk_gate_n |=> $stable(dq_data_out)
		&& $stable(burst_active)) else $error("gated edge changed state");
	a_burst_stop: assert property (load_s ##0 !sel |=> !burst_active)
		else $error("burst kept after deselect");
	a_burst_start: assert property (load_s ##0 sel |=> burst_active)
		else $error("load did not start a burst");
	a_idle_adv: assert property (!clk_gate_n && advance_or_load
		&& !burst_active |=> !burst_active) else $error("idle advance");
endmodule // pbsa_checker
bind pbsa_core pbsa_checker chk (.clk(clk), .resetn(resetn),
	.clk_gate_n(clk_gate_n), .chip_sel_a_n(chip_sel_a_n),
	.chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n),
	.advance_or_load(advance_or_load), .read_write(read_write),
	.out_en_n(out_en_n), .dq_data_out(dq_data_out),
	.dq_data_oe_n(dq_data_oe_n), .burst_active(burst_active));
`default_nettype wire

// ### sim/pbsa_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller end of the data lines; released lines show the inverse of the
// last value so a sample taken at the wrong edge cannot match by luck
module pbsa_ctl_model
	import pbsa_pkg::*;
(
	input wire logic clk,
	input wire logic drv,
	input wire logic [pbsa_pkg::WORD_W-1:0] wr_word,
	input wire logic dev_oe_n,
	input wire logic [pbsa_pkg::WORD_W-1:0] dev_word,
	output logic [pbsa_pkg::DATA_W-1:0] dq_data_in,
	output logic [pbsa_pkg::LANES-1:0] dq_parity_in
);
	logic [pbsa_pkg::WORD_W-1:0] last_q;
	always_comb
	begin
		{dq_parity_in, dq_data_in} = drv ? wr_word :
			(!dev_oe_n ? dev_word : ~last_q);
	end
	always_ff @(posedge clk)
	begin
		last_q <= {dq_parity_in, dq_data_in};
	end
endmodule // pbsa_ctl_model
`default_nettype wire

// ### sim/pipelined_burst_sram_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pipelined_burst_sram_access_bench;
	import pbsa_pkg::*;
	logic clk = 0, resetn = 0, gate = 0, oe = 0, ord = 0, adv = 0;
	logic rw = 1, drv = 0, oen;
	logic [1:0] s = 2'h1;
	logic [3:0] bw = 4'hF, pin, pout;
	logic [16:0] a = 17'h0;
	logic [35:0] wd = 36'h0;
	logic [31:0] din, dout;
	logic [36:0] obs;
	logic poen, bsy;
	logic [1:0] obs2;
	int num_errors = 0;
	int n_checks = 0;
	initial forever #5 clk = ~clk;
	// sampled mid-cycle so checks never race the design's own edge
	always @(negedge clk) obs <= {oen, pout, dout};
	always @(negedge clk) obs2 <= {poen, bsy};
	pbsa_core dut (.clk(clk), .resetn(resetn), .clk_gate_n(gate),
		.chip_sel_a_n(s == 2'h1), .chip_sel_b(s != 2'h2),
		.chip_sel_c_n(s == 2'h3), .advance_or_load(adv), .read_write(rw),
		.byte_write_n(bw), .burst_order_sel(ord), .out_en_n(oe),
		.addr_in(a), .dq_data_in(din), .dq_data_out(dout),
		.dq_data_oe_n(oen), .dq_parity_in(pin), .dq_parity_out(pout),
		.dq_parity_oe_n(poen), .burst_active(bsy));
	pbsa_ctl_model ctl (.clk(clk), .drv(drv), .wr_word(wd), .dev_oe_n(oen),
		.dev_word({pout, dout}), .dq_data_in(din), .dq_parity_in(pin));
	task automatic step(input logic l, input logic [1:0] c, input logic r,
		input logic [16:0] ad, input logic [3:0] b, input logic d = 0,
		input logic [35:0] w = 36'h0);
		adv <= !l;
		s <= c;
		rw <= r;
		a <= ad;
		bw <= b;
		drv <= d;
		wd <= w;
		@(posedge clk);
	endtask
	task automatic nop(input logic d = 0, input logic [35:0] w = 36'h0);
		step(1, 2'h1, 1, 17'h0, 4'hF, d, w);
	endtask
	task automatic wr(input logic [16:0] ad, input logic [3:0] b,
		input logic [35:0] w);
		step(1, 2'h0, 0, ad, b);
		nop();
		nop(1, w);
	endtask
	task automatic rd(input logic [16:0] ad, input logic [35:0] e,
		input logic d = 0);
		step(1, 2'h0, 1, ad, 4'h0);
		nop();
		nop(d, 36'hF_FFFF_FFFF);
		nop();
		`CHK(obs, {1'b0, e})
		`CHK(obs2[1], 1'b0)
	endtask
	function automatic logic [35:0] wv(input logic [16:0] ad);
		return {ad[3:0], 15'h2B5, ad};
	endfunction
	function automatic logic [35:0] mrg(input logic [35:0] o, n,
		input logic [3:0] b);
		mrg = o;
		for (int i = 0; i < 4; i++)
			if (!b[i])
			begin
				mrg[i*8 +: 8] = n[i*8 +: 8];
				mrg[32+i] = n[32+i];
			end
	endfunction
	task automatic t_rw();
		wr(17'h5, 4'h0, wv(17'h5));
		rd(17'h5, wv(17'h5));
		wr(17'h5, 4'hA, ~wv(17'h5));
		rd(17'h5, mrg(wv(17'h5), ~wv(17'h5), 4'hA), 1);
		rd(17'h5, mrg(wv(17'h5), ~wv(17'h5), 4'hA));
	endtask
	task automatic t_b2b();
		step(1, 2'h0, 0, 17'h7, 4'h0);
		step(1, 2'h0, 1, 17'h7, 4'h0);
		step(1, 2'h0, 1, 17'h7, 4'h0, 1, wv(17'h7));
		nop();
		nop();
		`CHK(obs, {1'b0, wv(17'h7)})
		nop();
		`CHK(obs, {1'b0, wv(17'h7)})
	endtask
	task automatic t_burst(input logic o);
		logic [1:0] k;
		ord <= o;
		for (int i = 8; i < 12; i++)
			wr(17'(i), 4'h0, wv(17'(i)));
		step(1, 2'h0, 1, 17'h9, 4'h0);
		step(0, 2'h0, 1, 17'h1FFFF, 4'h0);
		step(0, 2'h0, 1, 17'h1FFFF, 4'h0);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 0)
				step(0, 2'h0, 1, 17'h1FFFF, 4'h0);
			else
				nop();
			k = o ? (2'h1 ^ 2'(i)) : 2'(2'h1 + 2'(i));
			`CHK(obs, {1'b0, wv(17'h8 | 17'(k))})
			if (i == 0)
				`CHK(obs2[0], 1'b1)
		end
	endtask
	task automatic t_gate();
		step(1, 2'h0, 1, 17'h8, 4'h0);
		gate <= 1;
		nop();
		gate <= 0;
		nop();
		nop();
		`CHK(obs[36], 1'b1)
		nop();
		`CHK(obs, {1'b0, wv(17'h8)})
	endtask
	task automatic t_desel();
		for (int c = 1; c < 4; c++)
		begin
			step(1, 2'h0, 1, 17'hA, 4'h0);
			step(1, 2'(c), 1, 17'h8, 4'h0);
			nop();
			nop();
			`CHK(obs, {1'b0, wv(17'hA)})
			nop();
			`CHK(obs[36], 1'b1)
			`CHK(obs2[0], 1'b0)
		end
	endtask
	task automatic t_oe();
		step(1, 2'h0, 1, 17'hB, 4'h0);
		nop();
		nop();
		oe <= 1;
		nop();
		`CHK(obs[36], 1'b1)
		`CHK(obs2[1], 1'b1)
		oe <= 0;
	endtask
	task automatic conclude();
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1;
		`CHK(obs, {1'b1, 36'h0})
		t_rw();
		t_b2b();
		t_burst(0);
		t_burst(1);
		t_gate();
		t_desel();
		t_oe();
		conclude();
	end
	// the whole sequence needs about a hundred cycles; allow fifty times that
	initial
	begin
		#50000;
		num_errors++;
		conclude();
	end
endmodule // pipelined_burst_sram_access_bench
`default_nettype wire
